// ===== verilog/aagc_pkg.sv
// Purpose: Shared constants and helpers for the averaging, oscillator and pin-function register bank.
// Assumes: Eight channels, 8-bit register data, printed offsets used directly as addresses.
// Notes: Every offset, field position and reset value used by the design is named here once.

package aagc_pkg;

  // ----------------------------------------------------------------
  // Geometry
  // ----------------------------------------------------------------
  localparam int NCH = 8;
  localparam int DATA_W = 8;
  localparam int ADDR_W = 8;
  localparam int AVG_W = 3;
  localparam int DIV_W = 4;

  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [ADDR_W-1:0] ADDR_STATUS = 8'h00;
  localparam logic [ADDR_W-1:0] ADDR_GENERAL = 8'h01;
  localparam logic [ADDR_W-1:0] ADDR_AVG = 8'h03;
  localparam logic [ADDR_W-1:0] ADDR_OSC = 8'h04;
  localparam logic [ADDR_W-1:0] ADDR_FUNC = 8'h05;
  localparam logic [ADDR_W-1:0] ADDR_DIR = 8'h07;
  localparam logic [ADDR_W-1:0] ADDR_DRIVE = 8'h09;
  localparam logic [ADDR_W-1:0] ADDR_LEVEL = 8'h0b;
  localparam logic [ADDR_W-1:0] ADDR_INPUT = 8'h0d;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int BROWNOUT_BIT = 0;
  localparam int SWRST_BIT = 0;
  localparam int FORCE_BIT = 2;
  localparam int AVG_LSB = 0;
  localparam int DIV_LSB = 0;
  localparam int OSC_CHOICE_BIT = 4;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [AVG_W-1:0] RST_AVG_FIELD = 3'h0;
  localparam logic [DIV_W-1:0] RST_OSC_DIV = 4'h1;
  localparam logic RST_OSC_CHOICE = 1'b0;
  localparam logic [NCH-1:0] RST_CHAN = 8'h00;
  localparam logic RST_FORCE = 1'b0;
  localparam logic RST_BROWNOUT = 1'b1;
  localparam logic [NCH-1:0] PIN_RELEASED = 8'hff;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // Number of averaged samples for a ratio field: two to the field value.
  function automatic logic [7:0] aagc_pow2(input logic [AVG_W-1:0] field);
    aagc_pow2 = 8'h01 << field;
  endfunction : aagc_pow2

endpackage : aagc_pkg

// ===== verilog/aagc_rate_div.sv
// Purpose: Sampling-rate divider and averaging-window counter.
// Assumes: Divider and ratio fields come straight from their registers.
// Notes: Outputs are registered; a change of field takes effect one cycle later.

`timescale 1ns/1ps

module aagc_rate_div import aagc_pkg::*; #(
  parameter int CNT_W = DIV_W
) (
  input wire logic i_clk,
  input wire logic i_rst_b,
  input wire logic i_clr,
  input wire logic [AVG_W-1:0] i_avg_field,
  input wire logic [CNT_W-1:0] i_div,
  output logic o_sample_tick,
  output logic o_avg_done,
  output logic [7:0] o_avg_count
);

  generate
    if (CNT_W < 1 || CNT_W > 8) begin : g_bad_width
      $error("aagc_rate_div: divider width out of range");
    end
  endgenerate

  logic [CNT_W-1:0] cnt_reg;
  logic [7:0] samp_reg;
  logic tick_reg;
  logic done_reg;
  logic [7:0] count_reg;

  // ----------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------
  // The divider only slows sampling while averaging; without it every cycle samples.
  wire avg_on = (i_avg_field != '0);
  wire [CNT_W-1:0] limit = avg_on ? i_div : '0;
  wire cnt_hit = (cnt_reg >= limit);
  wire [CNT_W-1:0] cnt_next = cnt_hit ? '0 : CNT_W'(cnt_reg + 1'b1);
  wire [7:0] target = aagc_pow2(i_avg_field);
  wire samp_last = (samp_reg >= 8'(target - 8'h01));
  wire [7:0] samp_next = cnt_hit ? (samp_last ? 8'h00 : 8'(samp_reg + 8'h01)) : samp_reg;

  // Counters restart on a software reset so a new window starts clean.
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      cnt_reg <= '0;
      samp_reg <= 8'h00;
    end else if (i_clr) begin
      cnt_reg <= '0;
      samp_reg <= 8'h00;
    end else begin
      cnt_reg <= cnt_next;
      samp_reg <= samp_next;
    end
  end

  // Registered outputs.
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      tick_reg <= 1'b0;
      done_reg <= 1'b0;
      count_reg <= aagc_pow2(RST_AVG_FIELD);
    end else begin
      tick_reg <= cnt_hit & ~i_clr;
      done_reg <= cnt_hit & samp_last & ~i_clr;
      count_reg <= target;
    end
  end

  assign o_sample_tick = tick_reg;
  assign o_avg_done = done_reg;
  assign o_avg_count = count_reg;

endmodule : aagc_rate_div

// ===== verilog/aagc_pin_ctl.sv
// Purpose: Per-channel pin function, direction and drive logic.
// Assumes: Pad resolves the wire from output and active-low enable.
// Notes: All outputs are registered, so a setting reaches the pin one cycle after its register.

`timescale 1ns/1ps

module aagc_pin_ctl import aagc_pkg::*; #(
  parameter int W = NCH
) (
  input wire logic i_clk,
  input wire logic i_rst_b,
  input wire logic [W-1:0] i_func,
  input wire logic [W-1:0] i_dir,
  input wire logic [W-1:0] i_drive,
  input wire logic [W-1:0] i_level,
  input wire logic i_force,
  output logic [W-1:0] o_pin_out,
  output logic [W-1:0] o_pin_oe_b,
  output logic [W-1:0] o_analog_en
);

  generate
    if (W != NCH) begin : g_bad_width
      $error("aagc_pin_ctl: channel count must match the register width");
    end
  endgenerate

  logic [W-1:0] out_reg;
  logic [W-1:0] oe_b_reg;
  logic [W-1:0] analog_reg;

  // ----------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------
  // Level and drive type only matter for a digital output channel.
  wire [W-1:0] digital = i_func & ~{W{i_force}};
  wire [W-1:0] active = digital & i_dir;
  // Open drain pulls low only; push-pull drives both levels.
  wire [W-1:0] drive_en = active & (i_drive | ~i_level);
  wire [W-1:0] out_next = active & i_level & i_drive;

  // Pins come out of reset released and analog.
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      out_reg <= '0;
      oe_b_reg <= W'(PIN_RELEASED);
      analog_reg <= W'(PIN_RELEASED);
    end else begin
      out_reg <= out_next;
      oe_b_reg <= ~drive_en;
      analog_reg <= ~digital;
    end
  end

  assign o_pin_out = out_reg;
  assign o_pin_oe_b = oe_b_reg;
  assign o_analog_en = analog_reg;

endmodule : aagc_pin_ctl

// ===== verilog/aagc_regs.sv
// Purpose: Register bank for averaging ratio, oscillator and divider, channel function and pin control.
// Assumes: Plain register port; read data appear the cycle after the read strobe and only then.
// Notes: Unmapped reads return zero and unmapped writes are dropped.
//
// Function
// - Ratio field bits 2..0 selects two to the field value averaged samples.
// - Oscillator bit 4: clear means high-speed, set means low-power.
// - Divider field bits 3..0 sets sampling rate while averaging; resets to one.
// - All registers reset to zero except oscillator and status registers, which reset to one.
// - Each channel-function bit: zero analog input, one digital pin.
// - Each direction bit: clear is digital input, set is digital output.
// - Each drive bit: clear is open-drain, set is push-pull.
// - Each level bit sets the logic level driven on that digital output.
// - Input-level register reads back the sensed level of each pin.
// - Force-analog bit makes every channel analog regardless of other settings.
// - Software reset restores defaults, self-clears and sets the brownout flag.
//
// The address-and-strobe port is this design's own decision.

`timescale 1ns/1ps

module aagc_regs import aagc_pkg::*; #(
  parameter int CHANNELS = NCH
) (
  input wire logic i_clk,
  input wire logic i_rst_b,
  input wire logic [ADDR_W-1:0] i_addr,
  input wire logic [DATA_W-1:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [DATA_W-1:0] o_rdata,
  input wire logic [CHANNELS-1:0] i_pin_in,
  output logic [CHANNELS-1:0] o_pin_out,
  output logic [CHANNELS-1:0] o_pin_oe_b,
  output logic [CHANNELS-1:0] o_analog_en,
  output logic o_osc_low_power,
  output logic [DIV_W-1:0] o_clk_div,
  output logic [7:0] o_avg_count,
  output logic o_sample_tick,
  output logic o_avg_done
);

  generate
    if (CHANNELS != NCH) begin : g_bad_channels
      $error("aagc_regs: only eight channels fit the 8-bit registers");
    end
  endgenerate

  // ----------------------------------------------------------------
  // Register state
  // ----------------------------------------------------------------
  logic [AVG_W-1:0] avg_reg;
  logic osc_choice_reg;
  logic [DIV_W-1:0] div_reg;
  logic [NCH-1:0] func_reg;
  logic [NCH-1:0] dir_reg;
  logic [NCH-1:0] drive_reg;
  logic [NCH-1:0] level_reg;
  logic [NCH-1:0] input_reg;
  logic force_reg;
  logic brownout_reg;
  logic [DATA_W-1:0] rdata_reg;

  // ----------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------
  // One hit wire per register; the strobes qualify them below.
  wire hit_status = (i_addr == ADDR_STATUS);
  wire hit_general = (i_addr == ADDR_GENERAL);
  wire hit_avg = (i_addr == ADDR_AVG);
  wire hit_osc = (i_addr == ADDR_OSC);
  wire hit_func = (i_addr == ADDR_FUNC);
  wire hit_dir = (i_addr == ADDR_DIR);
  wire hit_drive = (i_addr == ADDR_DRIVE);
  wire hit_level = (i_addr == ADDR_LEVEL);
  wire hit_input = (i_addr == ADDR_INPUT);

  // Write enables per register.
  wire wr_status = i_wr & hit_status;
  wire wr_general = i_wr & hit_general;
  wire wr_avg = i_wr & hit_avg;
  wire wr_osc = i_wr & hit_osc;
  wire wr_func = i_wr & hit_func;
  wire wr_dir = i_wr & hit_dir;
  wire wr_drive = i_wr & hit_drive;
  wire wr_level = i_wr & hit_level;

  // The reset bit is never stored, so it reads back as zero by construction.
  wire swrst = wr_general & i_wdata[SWRST_BIT];
  wire brownout_clr = wr_status & i_wdata[BROWNOUT_BIT];

  // ----------------------------------------------------------------
  // Configuration registers
  // ----------------------------------------------------------------
  // Averaging ratio; a software reset takes precedence over the write data.
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      avg_reg <= RST_AVG_FIELD;
    end else if (swrst) begin
      avg_reg <= RST_AVG_FIELD;
    end else if (wr_avg) begin
      avg_reg <= i_wdata[AVG_LSB +: AVG_W];
    end
  end

  // Oscillator choice and sampling divider share one register.
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      osc_choice_reg <= RST_OSC_CHOICE;
      div_reg <= RST_OSC_DIV;
    end else if (swrst) begin
      osc_choice_reg <= RST_OSC_CHOICE;
      div_reg <= RST_OSC_DIV;
    end else if (wr_osc) begin
      osc_choice_reg <= i_wdata[OSC_CHOICE_BIT];
      div_reg <= i_wdata[DIV_LSB +: DIV_W];
    end
  end

  // Channel function and direction.
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      func_reg <= RST_CHAN;
      dir_reg <= RST_CHAN;
    end else if (swrst) begin
      func_reg <= RST_CHAN;
      dir_reg <= RST_CHAN;
    end else begin
      if (wr_func) begin
        func_reg <= i_wdata;
      end
      if (wr_dir) begin
        dir_reg <= i_wdata;
      end
    end
  end

  // Output drive type and level.
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      drive_reg <= RST_CHAN;
      level_reg <= RST_CHAN;
    end else if (swrst) begin
      drive_reg <= RST_CHAN;
      level_reg <= RST_CHAN;
    end else begin
      if (wr_drive) begin
        drive_reg <= i_wdata;
      end
      if (wr_level) begin
        level_reg <= i_wdata;
      end
    end
  end

  // Force-analog control; cleared by software reset like the rest.
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      force_reg <= RST_FORCE;
    end else if (swrst) begin
      force_reg <= RST_FORCE;
    end else if (wr_general) begin
      force_reg <= i_wdata[FORCE_BIT];
    end
  end

  // Brownout flag: set by power-on and software reset, cleared by writing one.
  // The set is tested first so a reset never loses to a clear.
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      brownout_reg <= RST_BROWNOUT;
    end else if (swrst) begin
      brownout_reg <= 1'b1;
    end else if (brownout_clr) begin
      brownout_reg <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Pin sensing and read path
  // ----------------------------------------------------------------
  // Pins are synchronous to the clock, so one register stage is enough.
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      input_reg <= RST_CHAN;
    end else if (swrst) begin
      input_reg <= RST_CHAN;
    end else begin
      input_reg <= i_pin_in;
    end
  end

  // Read views; reserved bits are zero.
  wire [DATA_W-1:0] status_val = {7'h00, brownout_reg};
  wire [DATA_W-1:0] general_val = {7'h00, force_reg} << FORCE_BIT;
  wire [DATA_W-1:0] avg_val = {5'h00, avg_reg};
  wire [DATA_W-1:0] osc_val = ({7'h00, osc_choice_reg} << OSC_CHOICE_BIT) | {4'h0, div_reg};
  wire [DATA_W-1:0] rd_mux =
    hit_status ? status_val :
    hit_general ? general_val :
    hit_avg ? avg_val :
    hit_osc ? osc_val :
    hit_func ? func_reg :
    hit_dir ? dir_reg :
    hit_drive ? drive_reg :
    hit_level ? level_reg :
    hit_input ? input_reg :
    8'h00;

  // Read data stand for exactly one cycle; zero otherwise so stale data never linger.
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      rdata_reg <= 8'h00;
    end else begin
      rdata_reg <= i_rd ? rd_mux : 8'h00;
    end
  end

  assign o_rdata = rdata_reg;
  assign o_osc_low_power = osc_choice_reg;
  assign o_clk_div = div_reg;

  // ----------------------------------------------------------------
  // Sub-blocks
  // ----------------------------------------------------------------
  aagc_rate_div #(
    .CNT_W(DIV_W)
  ) u_rate_div (
    .i_clk(i_clk),
    .i_rst_b(i_rst_b),
    .i_clr(swrst),
    .i_avg_field(avg_reg),
    .i_div(div_reg),
    .o_sample_tick(o_sample_tick),
    .o_avg_done(o_avg_done),
    .o_avg_count(o_avg_count)
  );

  aagc_pin_ctl #(
    .W(NCH)
  ) u_pin_ctl (
    .i_clk(i_clk),
    .i_rst_b(i_rst_b),
    .i_func(func_reg),
    .i_dir(dir_reg),
    .i_drive(drive_reg),
    .i_level(level_reg),
    .i_force(force_reg),
    .o_pin_out(o_pin_out),
    .o_pin_oe_b(o_pin_oe_b),
    .o_analog_en(o_analog_en)
  );

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  // Sample count follows the ratio field once it has settled.
  chk_avg_count_pow2 : assert property (
    @(posedge i_clk) disable iff (!i_rst_b)
    $stable(avg_reg) |-> o_avg_count == aagc_pow2(avg_reg))
    else $error("average count does not match ratio field");

  // A written oscillator bit appears on the choice output next cycle.
  chk_osc_choice_write : assert property (
    @(posedge i_clk) disable iff (!i_rst_b)
    wr_osc |=> o_osc_low_power == $past(i_wdata[OSC_CHOICE_BIT]))
    else $error("oscillator choice not taken from write");

  // With averaging on and divider one, ticks come every second cycle.
  chk_div_tick_period : assert property (
    @(posedge i_clk) disable iff (!i_rst_b)
    (o_sample_tick && avg_reg != 3'h0 && div_reg == 4'h1 && !i_wr && $stable(div_reg) && $stable(avg_reg))
    ##1 !swrst |-> !o_sample_tick ##1 o_sample_tick)
    else $error("sample tick period wrong for divider one");

  // After a software reset the oscillator register holds its nonzero default.
  chk_reset_defaults : assert property (
    @(posedge i_clk) disable iff (!i_rst_b)
    swrst |=> osc_val == 8'h01 && avg_reg == 3'h0 && drive_reg == 8'h00 && level_reg == 8'h00)
    else $error("register defaults wrong after software reset");

  // Analog enable is the inverse of the function register unless forced.
  chk_analog_function : assert property (
    @(posedge i_clk) disable iff (!i_rst_b)
    !force_reg |=> o_analog_en == ~$past(func_reg))
    else $error("analog enable does not follow channel function");

  // A digital input never drives its pin.
  chk_input_released : assert property (
    @(posedge i_clk) disable iff (!i_rst_b)
    1'b1 |=> ($past(~dir_reg) & ~o_pin_oe_b) == 8'h00)
    else $error("input channel is driving its pin");

  // Push-pull digital outputs drive continuously.
  chk_push_pull_drive : assert property (
    @(posedge i_clk) disable iff (!i_rst_b)
    !force_reg |=> ($past(func_reg & dir_reg & drive_reg) & o_pin_oe_b) == 8'h00)
    else $error("push-pull output not driven");

  // Driven push-pull pins carry the level register; open-drain pins release at one.
  chk_level_driven : assert property (
    @(posedge i_clk) disable iff (!i_rst_b)
    !force_reg |=> ((o_pin_out ^ $past(level_reg)) & $past(func_reg & dir_reg & drive_reg)) == 8'h00
      && ($past(func_reg & dir_reg & ~drive_reg & level_reg) & ~o_pin_oe_b) == 8'h00)
    else $error("output level not as written");

  // Reading the input register returns the pin levels two cycles back.
  chk_input_readback : assert property (
    @(posedge i_clk) disable iff (!i_rst_b)
    (i_rd && hit_input && !$past(i_wr)) |=> o_rdata == $past(i_pin_in, 2))
    else $error("input readback does not show pin levels");

  // Forcing analog releases every pin for as long as the bit stays set.
  chk_force_all_analog : assert property (
    @(posedge i_clk) disable iff (!i_rst_b)
    force_reg |=> o_analog_en == 8'hff && o_pin_oe_b == 8'hff && o_pin_out == 8'h00)
    else $error("forced analog channel still digital");

  // Software reset sets the flag, clears the force bit and reads back zero.
  chk_swrst_brownout : assert property (
    @(posedge i_clk) disable iff (!i_rst_b)
    swrst |=> brownout_reg && !force_reg && func_reg == 8'h00 && general_val[SWRST_BIT] == 1'b0)
    else $error("software reset did not restore defaults");

  // Channels that are not digital outputs keep the pin released and low.
  chk_gated_drive : assert property (
    @(posedge i_clk) disable iff (!i_rst_b)
    1'b1 |=> ($past(~(func_reg & dir_reg)) & (~o_pin_oe_b | o_pin_out)) == 8'h00)
    else $error("non-output channel affects its pin");

  // A ratio write lands in its field the edge it is taken.
  chk_ratio_write : assert property (
    @(posedge i_clk) disable iff (!i_rst_b)
    wr_avg |=> avg_reg == $past(i_wdata[AVG_LSB +: AVG_W]))
    else $error("ratio field not taken from write");

  // A divider write reaches the divider output the next cycle.
  chk_divider_write : assert property (
    @(posedge i_clk) disable iff (!i_rst_b)
    wr_osc |=> o_clk_div == $past(i_wdata[DIV_LSB +: DIV_W]))
    else $error("divider field not taken from write");

  // The input register follows the pins every cycle except after a software reset, which clears it, so a write to it has no effect.
  // The edge that releases reset is left out, since the flops still see reset there.
  chk_input_tracks_pins : assert property (
    @(posedge i_clk) disable iff (!i_rst_b)
    (i_rst_b && !swrst) |=> input_reg == $past(i_pin_in))
    else $error("input register does not follow the pins");

endmodule : aagc_regs

// ===== test/aagc_pad_model.sv
// Purpose: Pad model that resolves each channel wire from the block's drive and the board.
// Assumes: Every channel has an external pull-up; the bench may overdrive released pins.
// Notes: A released pin never shows the last driven value; it shows the board level.

`timescale 1ns/1ps

module aagc_pad_model (
  input wire logic [7:0] i_pin_out,
  input wire logic [7:0] i_pin_oe_b,
  input wire logic [7:0] i_ext,
  input wire logic [7:0] i_ext_en,
  output logic [7:0] o_pin
);
  // ----------------------------------------------------------------
  // Wire resolution
  // ----------------------------------------------------------------
  // The pull-up is what makes an open-drain high level appear at all.
  assign o_pin = (~i_pin_oe_b & i_pin_out) | (i_pin_oe_b & ((i_ext_en & i_ext) | ~i_ext_en));

endmodule : aagc_pad_model

// ===== test/tb_aagc_regs.sv
// Purpose: Self-checking bench for the register bank and its pin controls.
// Assumes: Register port with read data one cycle after the strobe.
// Notes: Checks are made 1 ns after an edge so registered outputs have settled.

`timescale 1ns/1ps

module tb_aagc_regs;
  import aagc_pkg::*;
  logic i_clk = 1'b0;
  logic i_rst_b = 1'b0;
  logic [7:0] i_addr = 8'h00;
  logic [7:0] i_wdata = 8'h00;
  logic i_wr = 1'b0;
  logic i_rd = 1'b0;
  logic [7:0] o_rdata, pin, pout, poe_b, aen, acnt, ext = 8'h00, ext_en = 8'h00;
  logic osc, tick, done;
  logic [3:0] cdiv;
  int err_count = 0;
  int n_compared = 0;
  int cyc = 0;
  int n;
  logic d;
  logic [7:0] ra[8] = '{8'h00, 8'h01, 8'h03, 8'h04, 8'h05, 8'h07, 8'h09, 8'h0b};
  logic [7:0] rv[8] = '{8'h01, 8'h00, 8'h00, 8'h01, 8'h00, 8'h00, 8'h00, 8'h00};
  logic [7:0] wa[7] = '{8'h03, 8'h04, 8'h05, 8'h07, 8'h09, 8'h0b, 8'h02};
  logic [7:0] wv[7] = '{8'h07, 8'h1f, 8'hff, 8'hff, 8'hff, 8'hff, 8'h00};

  aagc_regs dut_u (.i_clk(i_clk), .i_rst_b(i_rst_b), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr),
    .i_rd(i_rd), .o_rdata(o_rdata), .i_pin_in(pin), .o_pin_out(pout), .o_pin_oe_b(poe_b),
    .o_analog_en(aen), .o_osc_low_power(osc), .o_clk_div(cdiv), .o_avg_count(acnt),
    .o_sample_tick(tick), .o_avg_done(done));
  aagc_pad_model pad_u (.i_pin_out(pout), .i_pin_oe_b(poe_b), .i_ext(ext), .i_ext_en(ext_en), .o_pin(pin));

  // ----------------------------------------------------------------
  // Clock, timeout and shared tasks
  // ----------------------------------------------------------------
  // The ceiling is far above the roughly 150 cycles the tests need.
  always #25 i_clk = ~i_clk;
  always @(posedge i_clk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      err_count++;
      close_out();
    end
  end

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp) begin
      err_count++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // A gap cycle after each strobe keeps a signal from being assigned twice in one step.
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    i_addr <= a;
    i_wdata <= v;
    i_wr <= 1'b1;
    @(posedge i_clk);
    i_wr <= 1'b0;
    @(posedge i_clk);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    i_addr <= a;
    i_rd <= 1'b1;
    @(posedge i_clk);
    i_rd <= 1'b0;
    #1 chk(o_rdata, exp);
    @(posedge i_clk);
  endtask : rd

  // Returns the edges counted up to the next sample tick, bounded.
  task automatic wtick(output int k);
    k = 0;
    do begin
      @(posedge i_clk);
      #1 k++;
    end while (tick !== 1'b1 && k < 100);
  endtask : wtick

  task automatic close_out();
    $display("compared %0d, mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : close_out

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (5) @(posedge i_clk);
    i_rst_b <= 1'b1;
    @(posedge i_clk);
    #1 chk(cdiv, 8'h01);
    chk(acnt, 8'h01);
    chk(aen, 8'hff);
    chk(poe_b, 8'hff);
    chk({7'h00, osc}, 8'h00);
    @(posedge i_clk);
    for (int i = 0; i < 8; i++) rd(ra[i], rv[i]);
    // Fields are masked to their width; the unmapped place reads zero.
    for (int i = 0; i < 7; i++) wr(wa[i], 8'hff);
    for (int i = 0; i < 7; i++) rd(wa[i], wv[i]);
    #1 chk({7'h00, osc}, 8'h01);
    chk(cdiv, 8'h0f);
    @(posedge i_clk);
    for (int f = 0; f < 8; f++) begin
      wr(8'h03, f[7:0]);
      #1 chk(acnt, 8'h01 << f);
      @(posedge i_clk);
    end
    // Divide by four with a two-sample window, then no averaging.
    wr(8'h03, 8'h01);
    wr(8'h04, 8'h03);
    wtick(n);
    wtick(n);
    chk(n[7:0], 8'h04);
    d = done;
    wtick(n);
    chk(8'(d) + 8'(done), 8'h01);
    @(posedge i_clk);
    wr(8'h03, 8'h00);
    wtick(n);
    wtick(n);
    chk(n[7:0], 8'h01);
    @(posedge i_clk);
    // Mixed pins: 0 and 2 push-pull, 1 open-drain high, 3 open-drain low, 4-7 inputs.
    wr(8'h05, 8'hff);
    wr(8'h07, 8'h0f);
    wr(8'h09, 8'hf5);
    wr(8'h0b, 8'hf3);
    wr(8'h0d, 8'h00);
    ext_en <= 8'hf0;
    ext <= 8'ha0;
    repeat (3) @(posedge i_clk);
    #1 chk(poe_b, 8'hf2);
    chk(pout, 8'h01);
    chk(aen, 8'h00);
    @(posedge i_clk);
    rd(8'h0d, 8'ha3);
    wr(8'h05, 8'h0f);
    #1 @(posedge i_clk);
    #1 chk(aen, 8'hf0);
    @(posedge i_clk);
    wr(8'h01, 8'h04);
    @(posedge i_clk);
    #1 chk(aen, 8'hff);
    chk(poe_b, 8'hff);
    chk(pout, 8'h00);
    @(posedge i_clk);
    rd(8'h01, 8'h04);
    wr(8'h00, 8'h01);
    rd(8'h00, 8'h00);
    wr(8'h01, 8'h05);
    rd(8'h01, 8'h00);
    rd(8'h00, 8'h01);
    rd(8'h04, 8'h01);
    rd(8'h05, 8'h00);
    rd(8'h0b, 8'h00);
    // Default divider of one with averaging on: a tick every second cycle.
    wr(8'h03, 8'h02);
    wtick(n);
    wtick(n);
    chk(n[7:0], 8'h02);
    close_out();
  end

endmodule : tb_aagc_regs
